/* File: hdl/tscm_params.svh */
// Purpose: Timing constants for the temperature-sense and control monitor
// Assumes: 25 MHz clock
// Notes:   Times in milliseconds, counts derived from the clock rate
`ifndef TSCM_PARAMS_SVH
`define TSCM_PARAMS_SVH
`define TSCM_CLK_HZ 25000000
`define TSCM_BIAS_MS 24
`define TSCM_DEGLITCH_MS 10
`define TSCM_MON_PRIO_MS 35
`define TSCM_MON_STD_MS 235
`define TSCM_BIAS_CYC (`TSCM_BIAS_MS * (`TSCM_CLK_HZ / 1000))
`define TSCM_DEGLITCH_CYC (`TSCM_DEGLITCH_MS * (`TSCM_CLK_HZ / 1000))
`define TSCM_MON_PRIO_CYC (`TSCM_MON_PRIO_MS * (`TSCM_CLK_HZ / 1000))
`define TSCM_MON_STD_CYC (`TSCM_MON_STD_MS * (`TSCM_CLK_HZ / 1000))
`endif

/* File: hdl/tscm_pkg.sv */
// Purpose: Types for the temperature-sense and control monitor
// Assumes: Nothing beyond the parameter header
// Notes:   Timing figures live in tscm_params.svh
package tscm_pkg;
    typedef enum logic [1:0] {
        TSCM_BIAS,
        TSCM_MON,
        TSCM_OFF
    } tscm_phase_e;

    typedef struct packed {
        logic hot;
        logic cold;
        logic host_ctrl;
        logic fault;
        logic charge_done;
        logic thermal_off;
    } tscm_status_s;
endpackage

/* File: hdl/tscm_deglitch.sv */
// Purpose: Deglitch filter, output follows input after a stable run
// Assumes: Input synchronous to clk_i
// Notes:   Counter restarts whenever the input agrees with the output
`timescale 1ns/1ps
`default_nettype none
module tscm_deglitch #(
    parameter int CYCLES = 250000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Filter
    input wire logic clear_i,
    input wire logic raw_i,
    output logic filt_o
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic filt_ff;
    logic nxt_filt;

    always_comb begin
        nxt_cnt = '0;
        nxt_filt = filt_ff;
        if (clear_i) begin
            nxt_filt = 1'b0;
        end else if (raw_i != filt_ff) begin
            if (cnt_ff == CW'(CYCLES - 1)) begin
                nxt_filt = raw_i;
            end else begin
                nxt_cnt = cnt_ff + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_ff <= '0;
            filt_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            filt_ff <= nxt_filt;
        end
    end

    assign filt_o = filt_ff;
endmodule // tscm_deglitch
`default_nettype wire

/* File: hdl/tscm_monitor.sv */
// Purpose: Periodic thermistor bias, temperature read and host-control watch
// Assumes: Comparator inputs come from analog compare blocks, synchronous
// Notes:   Shutdown is latched until reset; host requests are sampled only
//          while the bias is released
//
// Summary of operation
// R01 - Hot and cold comparators judge the sense pin as a ratio of bias.
// R02 - Each cycle starts with the sample window driving the bias for 24 ms.
// R03 - Comparators pass a 10 ms deglitch during the window and set temperature state.
// R04 - At window end the window signal drops and the bias floats.
// R05 - Then the pin is watched against 100 mV for 35 or 235 ms.
// R06 - Pin above 100 mV in that period sets the host-control flag.
// R07 - Host keeps its driver hi-z in normal operation.
// R08 - Host pulling pin low requests fault shutdown with fault indication.
// R09 - Host pulling pin to battery requests shutdown with charge-done indication.
// R10 - Die over-temperature turns the output regulator off.
// R11 - Bias window and monitoring period repeat continuously while operating.
// R12 - Open-drain status output is on whenever the supply output is enabled.
`timescale 1ns/1ps
`default_nettype none
`include "tscm_params.svh"
module tscm_monitor #(
    parameter int BIAS_CYC = `TSCM_BIAS_CYC,
    parameter int DEGLITCH_CYC = `TSCM_DEGLITCH_CYC,
    parameter int MON_PRIO_CYC = `TSCM_MON_PRIO_CYC,
    parameter int MON_STD_CYC = `TSCM_MON_STD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Analog comparator results
    input wire logic hot_cmp_i,
    input wire logic cold_cmp_i,
    input wire logic ctrl_above_ref_i,
    input wire logic ctrl_pulled_low_i,
    input wire logic die_overtemp_i,
    // Operating context
    input wire logic priority_pkt_i,
    input wire logic supply_ready_i,
    // Pin controls
    output logic sense_sample_window_o,
    output logic thermistor_bias_out_o,
    output logic thermistor_bias_oe_n_o,
    output logic supply_status_out_o,
    output logic supply_status_oe_n_o,
    // Regulator and status
    output logic regulator_en_o,
    output tscm_pkg::tscm_status_s status_o
);
    localparam int TW = $clog2(MON_STD_CYC + 1);

    // ----------------------------------------
    // Phase sequencer
    // ----------------------------------------
    tscm_pkg::tscm_phase_e phase_ff;
    tscm_pkg::tscm_phase_e nxt_phase;
    logic [TW-1:0] tmr_ff;
    logic [TW-1:0] nxt_tmr;
    logic hot_f;
    logic cold_f;
    logic in_bias;
    logic shutdown;
    logic [TW-1:0] mon_last;

    function automatic logic [TW-1:0] last_of(input int cyc);
        return TW'(cyc - 1);
    endfunction

    assign in_bias = (phase_ff == tscm_pkg::TSCM_BIAS);
    assign mon_last = last_of(priority_pkt_i ? MON_PRIO_CYC : MON_STD_CYC); // see R05

    always_comb begin
        nxt_phase = phase_ff;
        nxt_tmr = tmr_ff + TW'(1);
        unique case (phase_ff)
            tscm_pkg::TSCM_BIAS: begin
                if (tmr_ff == last_of(BIAS_CYC)) begin // see R04
                    nxt_phase = tscm_pkg::TSCM_MON;
                    nxt_tmr = '0;
                end
            end
            tscm_pkg::TSCM_MON: begin
                // Period length follows the packet type in force at each cycle
                if (tmr_ff >= mon_last) begin // see R05
                    nxt_phase = tscm_pkg::TSCM_BIAS; // see R11
                    nxt_tmr = '0;
                end
            end
            tscm_pkg::TSCM_OFF: begin
                nxt_tmr = '0;
            end
        endcase
        if (shutdown) begin
            nxt_phase = tscm_pkg::TSCM_OFF;
            nxt_tmr = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase_ff <= tscm_pkg::TSCM_BIAS; // see R02
            tmr_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            tmr_ff <= nxt_tmr;
        end
    end

    // ----------------------------------------
    // Comparator deglitch
    // ----------------------------------------
    // Filters restart each window so a stale reading never carries over
    tscm_deglitch #(.CYCLES(DEGLITCH_CYC)) u_hot (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(!in_bias),
        .raw_i(hot_cmp_i), // see R01
        .filt_o(hot_f) // see R03
    );
    tscm_deglitch #(.CYCLES(DEGLITCH_CYC)) u_cold (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(!in_bias),
        .raw_i(cold_cmp_i), // see R01
        .filt_o(cold_f) // see R03
    );

    // ----------------------------------------
    // Status and shutdown
    // ----------------------------------------
    tscm_pkg::tscm_status_s st_ff;
    tscm_pkg::tscm_status_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (in_bias && tmr_ff == last_of(BIAS_CYC)) begin
            nxt_st.hot = hot_f; // see R03
            nxt_st.cold = cold_f;
        end
        if (phase_ff == tscm_pkg::TSCM_MON) begin
            if (ctrl_above_ref_i) begin
                nxt_st.host_ctrl = 1'b1; // see R06
                nxt_st.charge_done = 1'b1; // see R09
            end
            if (ctrl_pulled_low_i) begin
                nxt_st.fault = 1'b1; // see R08
            end
        end
        if (die_overtemp_i) begin
            nxt_st.thermal_off = 1'b1; // see R10
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign shutdown = st_ff.hot | st_ff.cold | st_ff.fault | st_ff.charge_done
        | st_ff.thermal_off;
    assign status_o = st_ff;

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic reg_en_ff;
    logic nxt_reg_en;

    always_comb begin
        nxt_reg_en = supply_ready_i & ~shutdown & ~die_overtemp_i; // see R10
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_en_ff <= 1'b0;
        end else begin
            reg_en_ff <= nxt_reg_en;
        end
    end

    assign regulator_en_o = reg_en_ff;
    assign sense_sample_window_o = in_bias; // see R02
    assign thermistor_bias_out_o = 1'b1;
    assign thermistor_bias_oe_n_o = ~in_bias; // see R04
    assign supply_status_out_o = 1'b0;
    assign supply_status_oe_n_o = ~reg_en_ff; // see R12

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    int unsigned win_cnt;
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !sense_sample_window_o) begin
            win_cnt <= 0;
        end else begin
            win_cnt <= win_cnt + 1;
        end
    end

    // Counts monitor cycles apart from the sequencer timer
    int unsigned mon_cnt;
    always_ff @(posedge clk_i) begin
        if (!resetn_i || phase_ff != tscm_pkg::TSCM_MON) begin
            mon_cnt <= 0;
        end else begin
            mon_cnt <= mon_cnt + 1;
        end
    end

    a_window_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R02
        sense_sample_window_o |-> win_cnt < BIAS_CYC) else $error("bias window too long");
    a_monitor_len: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R05
        (phase_ff == tscm_pkg::TSCM_MON) |-> mon_cnt < MON_STD_CYC)
        else $error("monitor period too long");
    a_window_end: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R04
        (in_bias && tmr_ff == last_of(BIAS_CYC) && !shutdown) |=> !sense_sample_window_o
        && thermistor_bias_oe_n_o) else $error("bias not released at window end");
    a_bias_float: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R04
        !sense_sample_window_o |-> thermistor_bias_oe_n_o) else $error("bias driven outside window");
    a_host_flag: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R06
        (phase_ff == tscm_pkg::TSCM_MON && ctrl_above_ref_i) |=> status_o.host_ctrl)
        else $error("host control not flagged");
    a_fault_stop: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R08
        (phase_ff == tscm_pkg::TSCM_MON && ctrl_pulled_low_i) |=> ##1 !regulator_en_o)
        else $error("fault did not stop regulator");
    a_done_stop: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R09
        status_o.charge_done |=> !regulator_en_o) else $error("charge done kept regulator on");
    a_thermal_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R10
        die_overtemp_i |=> !regulator_en_o) else $error("regulator on in overtemperature");
    a_status_pin: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R12
        supply_status_oe_n_o == !regulator_en_o) else $error("status pin mismatch");
    a_repeat_cycle: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R11
        (phase_ff == tscm_pkg::TSCM_MON && !shutdown
        && mon_cnt >= (priority_pkt_i ? MON_PRIO_CYC : MON_STD_CYC) - 1)
        |=> sense_sample_window_o)
        else $error("monitor period did not end");
    a_temp_latch: assert property (@(posedge clk_i) disable iff (!resetn_i) // see R03
        (in_bias && tmr_ff == last_of(BIAS_CYC)) |=> status_o.hot == $past(hot_f))
        else $error("hot state not captured");

    c_window: cover property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(sense_sample_window_o));
    c_host: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(status_o.host_ctrl));
    c_fault: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(status_o.fault));
    c_hot: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(status_o.hot));
endmodule // tscm_monitor
`default_nettype wire

/* File: test/tscm_partner.sv */
// Purpose: Far-side model, thermistor divider and host three-state driver
// Assumes: Pin levels reach the device as comparator results
// Notes:   A floating bias gives no ratio, so the comparators toggle
`timescale 1ns/1ps
`default_nettype none
module tscm_partner (
    // Clock
    input wire logic clk_i,
    // Scenario controls
    input wire logic [1:0] temp_sel_i,
    input wire logic [1:0] host_mode_i,
    // Device side
    input wire logic bias_oe_n_i,
    output logic hot_cmp_o,
    output logic cold_cmp_o,
    output logic above_ref_o,
    output logic pulled_low_o
);
    logic junk_ff = 1'b0;
    always @(posedge clk_i) begin
        junk_ff <= ~junk_ff;
    end
    always_comb begin
        above_ref_o = (host_mode_i == 2'h1) | ~bias_oe_n_i;
        pulled_low_o = (host_mode_i == 2'h2);
        case (host_mode_i)
            2'h1: begin
                hot_cmp_o = 1'b0;
                cold_cmp_o = 1'b1;
            end
            2'h2: begin
                hot_cmp_o = 1'b1;
                cold_cmp_o = 1'b0;
            end
            default: begin
                hot_cmp_o = bias_oe_n_i ? junk_ff : (temp_sel_i == 2'h1);
                cold_cmp_o = bias_oe_n_i ? ~junk_ff : (temp_sel_i == 2'h2);
            end
        endcase
    end
endmodule // tscm_partner
`default_nettype wire

/* File: test/tb.sv */
// Purpose: Self-checking bench for the sense and control monitor
// Assumes: Short timing parameters, one clock cycle is 40 units of time (40 ns)
// Notes:   Inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic die = 1'b0;
    logic prio = 1'b1;
    logic ready = 1'b1;
    logic [1:0] temp_sel = 2'h0;
    logic [1:0] host_mode = 2'h0;
    logic hot_c, cold_c, above, low_c;
    logic window, bias_out, bias_oe_n, stat_out, stat_oe_n, reg_en;
    tscm_pkg::tscm_status_s st;
    int fail_count = 0;
    int check_count = 0;
    int n;
    tscm_monitor #(.BIAS_CYC(24), .DEGLITCH_CYC(10), .MON_PRIO_CYC(35), .MON_STD_CYC(235))
    tscm_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i), .hot_cmp_i(hot_c),
        .cold_cmp_i(cold_c), .ctrl_above_ref_i(above), .ctrl_pulled_low_i(low_c),
        .die_overtemp_i(die), .priority_pkt_i(prio), .supply_ready_i(ready),
        .sense_sample_window_o(window), .thermistor_bias_out_o(bias_out),
        .thermistor_bias_oe_n_o(bias_oe_n), .supply_status_out_o(stat_out),
        .supply_status_oe_n_o(stat_oe_n), .regulator_en_o(reg_en), .status_o(st));
    tscm_partner tscm_partner_inst (.clk_i(clk_i), .temp_sel_i(temp_sel),
        .host_mode_i(host_mode), .bias_oe_n_i(bias_oe_n), .hot_cmp_o(hot_c),
        .cold_cmp_o(cold_c), .above_ref_o(above), .pulled_low_o(low_c));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic rst;
        resetn_i = 1'b0;
        temp_sel = 2'h0;
        host_mode = 2'h0;
        die = 1'b0;
        prio = 1'b1;
        ready = 1'b1;
        cyc(6);
        resetn_i = 1'b1;
    endtask
    task automatic wait_win(input logic lvl);
        for (int i = 0; i < 400 && window !== lvl; i++) begin
            cyc(1);
        end
        if (window !== lvl) begin
            fail_count++;
            $display("BAD %0t window wait ran out", $time);
            close_out();
        end
    endtask
    task automatic len(input logic lvl, output int cnt);
        cnt = 0;
        while (window === lvl && cnt < 400) begin
            chk(bias_oe_n, ~lvl);
            cnt++;
            cyc(1);
        end
    endtask
    task automatic t_cycle;
        rst();
        wait_win(1'b0);
        len(1'b0, n);
        chk(n == 35, 1'b1);
        prio = 1'b0;
        len(1'b1, n);
        chk(n == 24, 1'b1);
        len(1'b0, n);
        chk(n == 235, 1'b1);
        chk(reg_en, 1'b1);
        chk(stat_oe_n, 1'b0);
        chk(stat_out, 1'b0);
        chk(bias_out, 1'b1);
        ready = 1'b0;
        cyc(3);
        chk(stat_oe_n, 1'b1);
        ready = 1'b1;
        $display("test cycle done");
    endtask
    task automatic t_temp;
        rst();
        wait_win(1'b0);
        wait_win(1'b1);
        cyc(2);
        temp_sel = 2'h2;
        cyc(9);
        temp_sel = 2'h0;
        wait_win(1'b0);
        cyc(2);
        chk(st.cold, 1'b0);
        wait_win(1'b1);
        cyc(2);
        temp_sel = 2'h1;
        cyc(12);
        temp_sel = 2'h0;
        wait_win(1'b0);
        cyc(2);
        chk(st.hot, 1'b1);
        chk(reg_en, 1'b0);
        cyc(250);
        chk(window, 1'b0);
        rst();
        wait_win(1'b0);
        wait_win(1'b1);
        cyc(2);
        temp_sel = 2'h2;
        wait_win(1'b0);
        temp_sel = 2'h0;
        cyc(2);
        chk(st.cold, 1'b1);
        chk(st.hot, 1'b0);
        chk(reg_en, 1'b0);
        $display("test temperature done");
    endtask
    task automatic t_host(input logic [1:0] mode);
        rst();
        wait_win(1'b0);
        cyc(3);
        host_mode = mode;
        cyc(2);
        chk(st.charge_done, mode == 2'h1);
        chk(st.host_ctrl, mode == 2'h1);
        chk(st.fault, mode == 2'h2);
        cyc(2);
        chk(reg_en, 1'b0);
        chk(stat_oe_n, 1'b1);
        host_mode = 2'h0;
        cyc(40);
        chk(window, 1'b0);
        $display("test host done");
    endtask
    task automatic t_therm;
        rst();
        cyc(5);
        die = 1'b1;
        cyc(2);
        chk(reg_en, 1'b0);
        chk(st.thermal_off, 1'b1);
        die = 1'b0;
        cyc(3);
        chk(reg_en, 1'b0);
        $display("test thermal done");
    endtask
    initial begin
        t_cycle();
        t_temp();
        t_host(2'h1);
        t_host(2'h2);
        t_therm();
        close_out();
    end
endmodule // tb
`default_nettype wire
